// file: design/sbc_pkg.sv
package sbc_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_STANDBY_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h01;
  localparam int STANDBY_SELECT_BIT = 7;
  localparam int STS_MSB = 6;
  localparam int STS_LSB = 4;
  localparam int RSVD_BIT = 3;
  localparam int SCK_MSB = 2;
  localparam int SCK_LSB = 0;
  localparam logic [7:0] STANDBY_CONTROL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int WAIT_BASE_STATES = 8192;
  localparam logic [2:0] STS_MAX_CODE = 3'h5;
  localparam logic [2:0] SCK_MAX_CODE = 3'h5;
  localparam int WAIT_CNT_W = 19;
  localparam int DIV_CNT_W = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic standby_select;
    logic [2:0] sts;
    logic rsvd;
    logic [2:0] sck;
  } sbc_standby_control_t;

  typedef enum logic [6:0] {
    MODE_ACTIVE = 7'h01,
    MODE_SLEEP = 7'h02,
    MODE_SUBACT = 7'h04,
    MODE_SUBSLEEP = 7'h08,
    MODE_WATCH = 7'h10,
    MODE_STANDBY = 7'h20,
    MODE_OSC_WAIT = 7'h40
  } sbc_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sbc_bus_req_t;

  typedef struct packed {
    logic direct_transfer;
    logic low_speed_on;
  } sbc_lp_qual_t;

  typedef struct packed {
    sbc_standby_control_t ctrl;
    sbc_mode_t mode;
    logic [WAIT_CNT_W-1:0] wait_cnt;
    logic [DATA_W-1:0] rdata;
  } sbc_main_state_t;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic tick;
  } sbc_div_state_t;

endpackage

// file: design/sbc_clk_divider.sv
`timescale 1ns/1ps
module sbc_clk_divider
  import sbc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] sel,
  output logic tick
);

  // ----------------------------------------------------------------
  // Divider state
  // ----------------------------------------------------------------
  sbc_div_state_t st;
  sbc_div_state_t next_st;

  // Mask of low counter bits that must be all ones for a tick.
  function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [2:0] code);
    logic [DIV_CNT_W:0] one_hot;
    one_hot = '0;
    if (code > SCK_MAX_CODE) begin
      return '0;
    end
    one_hot[code] = 1'b1;
    return DIV_CNT_W'(one_hot - 1'b1);
  endfunction

  // One free running counter serves every ratio, so a change of
  // ratio takes effect within one period of the new clock.
  always_comb begin
    next_st = st;
    next_st.cnt = DIV_CNT_W'(st.cnt + 1'b1);
    next_st.tick = ((st.cnt & div_mask(sel)) == div_mask(sel));
  end

  // Registered tick keeps the output glitch free.
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DIV_FULL: assert property (@(posedge clk) disable iff (rst)
    ce && (sel == 3'h0 || sel > SCK_MAX_CODE) |=> tick)
    else $error("Undivided selection did not tick.");

  AST_DIV_HALF: assert property (@(posedge clk) disable iff (rst)
    ce && sel == 3'h1 && st.cnt[0] |=> tick)
    else $error("Half rate tick missing.");

endmodule

// file: design/sbc_standby_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Sleep, running fast, select clear: sleep mode.
// - Sleep, running fast, select set: standby/subactive/watch.
// - Sleep in subactive, select clear: subsleep.
// - Sleep in subactive, select set: watch/high-speed.
// - Mode transitions never alter standby select.
// - Bits 6:4 pick oscillator stabilization wait.
// - Wait codes give 8192 to 262144 states.
// - Bit 3 reads zero, ignores writes.
// - Bits 2:0 pick bus master clock.
// - Codes map full clock through clock/32.
// - All fields reset to zero.
// - Divider derives clock/2 through clock/32.
module sbc_standby_ctrl
  import sbc_pkg::*;
#(
  parameter int WAIT_BASE = WAIT_BASE_STATES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire sbc_bus_req_t bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire sbc_lp_qual_t lp_qual,
  output sbc_mode_t mode,
  output logic cpu_hold,
  output logic osc_stop,
  output logic medium_speed,
  output logic bus_clk_en
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sbc_main_state_t st;
  sbc_main_state_t next_st;
  logic div_tick;
  logic ctrl_wr;
  logic running_fast;
  logic running_sub;

  // Load value of the wait counter for a stabilization code. Reserved
  // codes saturate at the longest wait so a bad setting errs safe.
  function automatic logic [WAIT_CNT_W-1:0] wait_load(input logic [2:0] code);
    logic [2:0] eff;
    eff = (code > STS_MAX_CODE) ? STS_MAX_CODE : code;
    return WAIT_CNT_W'((WAIT_BASE << eff) - 1);
  endfunction

  // Readback image of the control register.
  function automatic logic [DATA_W-1:0] ctrl_image(input sbc_standby_control_t c);
    logic [DATA_W-1:0] img;
    img = '0;
    img[STANDBY_SELECT_BIT] = c.standby_select;
    img[STS_MSB:STS_LSB] = c.sts;
    img[SCK_MSB:SCK_LSB] = c.sck;
    return img;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign ctrl_wr = bus_req.wr && (bus_req.addr == OFS_STANDBY_CONTROL);
  assign running_fast = (st.mode == MODE_ACTIVE);
  assign running_sub = (st.mode == MODE_SUBACT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Register writes and mode sequencing share one process; a write in
  // the same cycle as a sleep takes effect for the next sleep only.
  always_comb begin
    next_st = st;
    next_st.rdata = '0;

    // Register writes; the reserved bit is never stored.
    if (ctrl_wr) begin
      next_st.ctrl.standby_select = bus_req.wdata[STANDBY_SELECT_BIT];
      next_st.ctrl.sts = bus_req.wdata[STS_MSB:STS_LSB];
      next_st.ctrl.sck = bus_req.wdata[SCK_MSB:SCK_LSB];
      next_st.ctrl.rsvd = 1'b0;
    end

    // Reads answer one cycle later and read zero elsewhere.
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_STANDBY_CONTROL: begin
          next_st.rdata = ctrl_image(st.ctrl);
        end
        OFS_MODE_STATUS: begin
          next_st.rdata = {1'b0, st.mode};
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end

    // Mode sequencing; the standby select is only ever changed by a
    // bus write, never by any of these transitions.
    case (st.mode)
      MODE_ACTIVE: begin
        if (sleep_exec) begin
          if (!st.ctrl.standby_select) begin
            next_st.mode = MODE_SLEEP;
          end else if (!lp_qual.low_speed_on) begin
            next_st.mode = MODE_STANDBY;
          end else if (lp_qual.direct_transfer) begin
            next_st.mode = MODE_SUBACT;
          end else begin
            next_st.mode = MODE_WATCH;
          end
        end
      end
      MODE_SUBACT: begin
        if (sleep_exec) begin
          if (!st.ctrl.standby_select) begin
            next_st.mode = MODE_SUBSLEEP;
          end else if (lp_qual.direct_transfer && !lp_qual.low_speed_on) begin
            // Main oscillator was stopped, so restart waits it out.
            next_st.mode = MODE_OSC_WAIT;
            next_st.wait_cnt = wait_load(st.ctrl.sts);
          end else begin
            next_st.mode = MODE_WATCH;
          end
        end
      end
      MODE_SLEEP: begin
        if (wake_irq) begin
          next_st.mode = MODE_ACTIVE;
        end
      end
      MODE_SUBSLEEP: begin
        if (wake_irq) begin
          next_st.mode = MODE_SUBACT;
        end
      end
      MODE_WATCH: begin
        if (wake_irq) begin
          if (lp_qual.low_speed_on) begin
            next_st.mode = MODE_SUBACT;
          end else begin
            next_st.mode = MODE_OSC_WAIT;
            next_st.wait_cnt = wait_load(st.ctrl.sts);
          end
        end
      end
      MODE_STANDBY: begin
        if (wake_irq) begin
          next_st.mode = MODE_OSC_WAIT;
          next_st.wait_cnt = wait_load(st.ctrl.sts);
        end
      end
      MODE_OSC_WAIT: begin
        // Each cycle here is one state of the restarted clock.
        if (st.wait_cnt == '0) begin
          next_st.mode = MODE_ACTIVE;
        end else begin
          next_st.wait_cnt = WAIT_CNT_W'(st.wait_cnt - 1'b1);
        end
      end
      default: begin
        next_st.mode = MODE_ACTIVE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // All fields clear at reset: sleep selection, shortest wait, full clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      st.ctrl <= sbc_standby_control_t'(STANDBY_CONTROL_RESET);
      st.mode <= MODE_ACTIVE;
      st.wait_cnt <= '0;
      st.rdata <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Bus master clock
  // ----------------------------------------------------------------
  // The divider runs on the system clock; in subclock modes the bus
  // clock enable is withheld since the ratio field does not apply there.
  sbc_clk_divider u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .sel(st.ctrl.sck),
    .tick(div_tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata = st.rdata;
  assign mode = st.mode;
  assign cpu_hold = !(running_fast || running_sub);
  assign osc_stop = (st.mode == MODE_WATCH) || (st.mode == MODE_STANDBY) ||
                    running_sub || (st.mode == MODE_SUBSLEEP);
  assign medium_speed = running_fast && (st.ctrl.sck != 3'h0);
  assign bus_clk_en = running_fast && div_tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Each sequence names the event that opens a group of checks; the
  // clock enable is part of every event, since a frozen cycle takes nothing.
  sequence s_fast_sleep(logic sel);
    ce && running_fast && sleep_exec && st.ctrl.standby_select == sel;
  endsequence

  sequence s_sub_sleep(logic sel);
    ce && running_sub && sleep_exec && st.ctrl.standby_select == sel;
  endsequence

  sequence s_wait_entry;
    ce && st.mode == MODE_STANDBY && wake_irq;
  endsequence

  sequence s_wake(sbc_mode_t src);
    ce && st.mode == src && wake_irq;
  endsequence

  sequence s_watch_wake(logic lso);
    ce && st.mode == MODE_WATCH && wake_irq && lp_qual.low_speed_on == lso;
  endsequence

  // Subactive straight back to high speed must still wait for the
  // main oscillator, which was stopped while the subclock ran.
  sequence s_direct_up;
    ce && running_sub && sleep_exec && st.ctrl.standby_select &&
      lp_qual.direct_transfer && !lp_qual.low_speed_on;
  endsequence

  sequence s_ctrl_write;
    ce && ctrl_wr;
  endsequence

  AST_FAST_SLEEP: assert property (
    s_fast_sleep(1'b0) |=> mode == MODE_SLEEP)
    else $error("Sleep with select clear did not enter sleep mode.");

  AST_FAST_STANDBY: assert property (
    s_fast_sleep(1'b1) |=> mode inside {MODE_STANDBY, MODE_SUBACT, MODE_WATCH})
    else $error("Sleep with select set entered a wrong mode.");

  AST_SUB_SUBSLEEP: assert property (
    s_sub_sleep(1'b0) |=> mode == MODE_SUBSLEEP)
    else $error("Subactive sleep with select clear missed subsleep.");

  AST_SUB_WATCH: assert property (
    s_sub_sleep(1'b1) |=> mode inside {MODE_WATCH, MODE_OSC_WAIT})
    else $error("Subactive sleep with select set entered a wrong mode.");

  AST_SELECT_KEPT: assert property (
    wake_irq && !ctrl_wr |=> $stable(st.ctrl.standby_select))
    else $error("Standby select changed on a wake transition.");

  AST_RSVD_ZERO: assert property (
    ce && bus_req.rd && bus_req.addr == OFS_STANDBY_CONTROL |=> rdata[RSVD_BIT] == 1'b0)
    else $error("Reserved bit read back as one.");

  AST_RESET_CLEAR: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> st.ctrl == '0 && mode == MODE_ACTIVE)
    else $error("Control register not clear after reset.");

  AST_WAIT_LOAD: assert property (
    s_wait_entry |=> mode == MODE_OSC_WAIT && st.wait_cnt == wait_load($past(st.ctrl.sts)))
    else $error("Stabilization counter loaded with a wrong count.");

  AST_WAIT_HOLD: assert property (
    mode == MODE_OSC_WAIT && st.wait_cnt != '0 |-> cpu_hold ##1 mode == MODE_OSC_WAIT)
    else $error("CPU released before the stabilization count ran out.");

  AST_WAIT_END: assert property (
    ce && mode == MODE_OSC_WAIT && st.wait_cnt == '0 |=> mode == MODE_ACTIVE && !cpu_hold)
    else $error("Stabilization wait did not end on count zero.");

  AST_FULL_CLOCK: assert property (
    ce && running_fast && st.ctrl.sck == 3'h0 && !ctrl_wr ##1 ce && running_fast
    |=> bus_clk_en || !running_fast)
    else $error("Undivided bus clock enable dropped.");

  AST_STANDBY_STOP: assert property (
    s_fast_sleep(1'b1) |=> osc_stop)
    else $error("Sleep with select set left the main oscillator running.");

  // Wake paths back toward the running modes.
  AST_SLEEP_WAKE: assert property (
    s_wake(MODE_SLEEP) |=> mode == MODE_ACTIVE)
    else $error("Wake from sleep did not return to active mode.");

  AST_SUBSLEEP_WAKE: assert property (
    s_wake(MODE_SUBSLEEP) |=> mode == MODE_SUBACT)
    else $error("Wake from subsleep did not return to subactive mode.");

  AST_WATCH_TO_SUB: assert property (
    s_watch_wake(1'b1) |=> mode == MODE_SUBACT && !cpu_hold)
    else $error("Watch wake with low speed on missed subactive mode.");

  AST_WATCH_TO_WAIT: assert property (
    s_watch_wake(1'b0) |=> mode == MODE_OSC_WAIT && cpu_hold)
    else $error("Watch wake to high speed skipped the stabilization wait.");

  // Counter loading and counting during the stabilization wait.
  AST_DIRECT_LOAD: assert property (
    s_direct_up |=> mode == MODE_OSC_WAIT &&
      st.wait_cnt == wait_load($past(st.ctrl.sts)))
    else $error("Direct transfer loaded a wrong stabilization count.");

  AST_WAIT_COUNT: assert property (
    ce && mode == MODE_OSC_WAIT && st.wait_cnt != '0 |=>
      st.wait_cnt == $past(st.wait_cnt) - 1'b1)
    else $error("Stabilization counter did not step down by one.");

  // Register fields and readback.
  AST_WRITE_FIELDS: assert property (
    s_ctrl_write |=> st.ctrl.sts == $past(bus_req.wdata[STS_MSB:STS_LSB]) &&
      st.ctrl.sck == $past(bus_req.wdata[SCK_MSB:SCK_LSB]) && !st.ctrl.rsvd)
    else $error("Control write did not store the wait and clock fields.");

  AST_READ_IMAGE: assert property (
    ce && bus_req.rd && bus_req.addr == OFS_STANDBY_CONTROL |=>
      rdata == {$past(st.ctrl.standby_select), $past(st.ctrl.sts), 1'b0, $past(st.ctrl.sck)})
    else $error("Control register read back a wrong image.");

  AST_CTRL_FROZEN: assert property (
    !ce |=> $stable(st.ctrl) && $stable(mode))
    else $error("Control register or mode moved with the clock enable low.");

endmodule

// file: tb/tb_standby_mode_and_bus_clock_select.sv
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Shared compare
// --------------------------------------------------------------------
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module tb_standby_mode_and_bus_clock_select;
  import sbc_pkg::*;

  // Short wait base keeps the longest stabilization wait at 128 cycles.
  localparam int WB = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  sbc_bus_req_t bus_req = '0;
  logic sleep_exec = 1'b0;
  logic wake_irq = 1'b0;
  sbc_lp_qual_t lp_qual = '0;
  logic [7:0] rdata;
  sbc_mode_t mode;
  logic cpu_hold;
  logic osc_stop;
  logic medium_speed;
  logic bus_clk_en;
  int err_total = 0;
  int tests_run = 0;
  int seed = 32'h05c4;
  int cnt;
  logic [7:0] ctrl_m = 8'h00;
  logic [7:0] d;

  // Free-running 250 MHz system clock.
  always #2 clk = ~clk;

  sbc_standby_ctrl #(.WAIT_BASE(WB)) i_dut (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .bus_req(bus_req),
    .rdata(rdata),
    .sleep_exec(sleep_exec),
    .wake_irq(wake_irq),
    .lp_qual(lp_qual),
    .mode(mode),
    .cpu_hold(cpu_hold),
    .osc_stop(osc_stop),
    .medium_speed(medium_speed),
    .bus_clk_en(bus_clk_en)
  );

  // ------------------------------------------------------------------
  // Bus and event tasks
  // ------------------------------------------------------------------
  task automatic wrap_up;
    $display("Counts: %0d mismatches in %0d comparisons", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The model register drops the reserved bit, as the hardware must.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    bus_req.wdata <= v;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    if (a == OFS_STANDBY_CONTROL && ce) ctrl_m = v & 8'hf7;
  endtask

  // Read data is looked at only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(posedge clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(nm, ex, rdata)
  endtask

  // One-cycle sleep or wake pulse, then the mode one cycle later.
  task automatic ev(input bit slp, input sbc_mode_t ex, input string nm);
    @(posedge clk);
    if (slp) sleep_exec <= 1'b1;
    else wake_irq <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    wake_irq <= 1'b0;
    #1;
    `CHK(nm, ex, mode)
  endtask

  // Counts the cycles spent in the stabilization wait, with a bound.
  task automatic wait_osc(input int n);
    int c;
    c = 0;
    while (mode === MODE_OSC_WAIT && c < 1000) begin
      @(posedge clk);
      #1;
      c++;
    end
    `CHK("osc wait length", n, c)
    if (c >= 1000) wrap_up();
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Flash access enable lives outside this block and stays clear here.
    rd(OFS_STANDBY_CONTROL, 8'h00, "ctrl reset");
    `CHK("mode reset", MODE_ACTIVE, mode)
    rd(8'h5a, 8'h00, "unmapped read");
    // Random control values; bit 3 must never stick.
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(OFS_STANDBY_CONTROL, d | 8'h08);
      rd(OFS_STANDBY_CONTROL, ctrl_m, "ctrl readback");
    end
    // Select clear: plain sleep, woken back to active.
    wr(OFS_STANDBY_CONTROL, 8'h05);
    ev(1, MODE_SLEEP, "sleep entry");
    `CHK("sleep cpu hold", 1'b1, cpu_hold)
    rd(OFS_MODE_STATUS, {1'b0, MODE_SLEEP}, "mode status");
    ev(0, MODE_ACTIVE, "sleep wake");
    // Standby for every wait code; reserved codes use the longest wait.
    for (int s = 0; s < 8; s++) begin
      // Longer codes stand in for the crystal case; the short base keeps it quick.
      wr(OFS_STANDBY_CONTROL, {1'b1, s[2:0], 4'h0});
      ev(1, MODE_STANDBY, "standby entry");
      `CHK("standby osc stop", 1'b1, osc_stop)
      ev(0, MODE_OSC_WAIT, "standby wake");
      `CHK("wait cpu hold", 1'b1, cpu_hold)
      `CHK("wait osc run", 1'b0, osc_stop)
      wait_osc(WB << ((s > 5) ? 5 : s));
      `CHK("wait end", MODE_ACTIVE, mode)
      rd(OFS_STANDBY_CONTROL, ctrl_m, "select kept");
    end
    // Sub-clock route: divider cleared before entry, shortest wait code.
    @(posedge clk) lp_qual <= 2'b11;
    wr(OFS_STANDBY_CONTROL, 8'h80);
    ev(1, MODE_SUBACT, "subactive entry");
    `CHK("subactive cpu hold", 1'b0, cpu_hold)
    wr(OFS_STANDBY_CONTROL, 8'h00);
    ev(1, MODE_SUBSLEEP, "subsleep entry");
    ev(0, MODE_SUBACT, "subsleep wake");
    @(posedge clk) lp_qual <= 2'b01;
    wr(OFS_STANDBY_CONTROL, 8'h80);
    ev(1, MODE_WATCH, "watch entry");
    ev(0, MODE_SUBACT, "watch wake");
    rd(OFS_STANDBY_CONTROL, 8'h80, "select kept");
    @(posedge clk) lp_qual <= 2'b10;
    ev(1, MODE_OSC_WAIT, "direct to high speed");
    wait_osc(WB);
    `CHK("high speed", MODE_ACTIVE, mode)
    // Watch from high speed, woken with low speed off: back through the wait.
    @(posedge clk) lp_qual <= 2'b01;
    ev(1, MODE_WATCH, "watch from high speed");
    @(posedge clk) lp_qual <= 2'b00;
    ev(0, MODE_OSC_WAIT, "watch wake to wait");
    wait_osc(WB);
    `CHK("watch to high speed", MODE_ACTIVE, mode)
    // Bus master clock share for every divider code.
    @(posedge clk) lp_qual <= 2'b00;
    for (int k = 0; k < 8; k++) begin
      wr(OFS_STANDBY_CONTROL, {5'h00, k[2:0]});
      repeat (64) @(posedge clk);
      cnt = 0;
      repeat (64) begin
        @(posedge clk);
        #1;
        if (bus_clk_en === 1'b1) cnt++;
      end
      `CHK("bus clock share", (k == 0 || k > 5) ? 64 : (64 >> k), cnt)
      if (k < 6) `CHK("medium speed", k != 0, medium_speed)
    end
    // Clock enable low freezes all state: the write and the sleep are lost.
    @(posedge clk) ce <= 1'b0;
    wr(OFS_STANDBY_CONTROL, 8'h80);
    ev(1, MODE_ACTIVE, "frozen sleep");
    @(posedge clk) ce <= 1'b1;
    rd(OFS_STANDBY_CONTROL, ctrl_m, "frozen write");
    wrap_up();
  end
endmodule
